// [core/gp_timer_regs.svh]
// register offsets, field positions, reset values and timing counts of the timer set
`ifndef GP_TIMER_REGS_SVH
`define GP_TIMER_REGS_SVH

// ****************************************************************
// register map (byte addresses, one word each)
// ****************************************************************
`define TMR_ADDR_W 8
`define TMR_BANK_STRIDE 8'h10
`define TMR_CTRL_OFS 8'h00
`define TMR_PERIOD_OFS 8'h04
`define TMR_COUNT_OFS 8'h08
`define TMR_IRQ_STAT_ADDR 8'h30
`define TMR_IRQ_MASK_ADDR 8'h34
`define TMR_WD_CTRL_ADDR 8'h38
`define TMR_WD_PERIOD_ADDR 8'h3c
`define TMR_WD_KICK_ADDR 8'h40
`define TMR_ROUTE_ADDR 8'h44
`define TMR_WD_COUNT_ADDR 8'h48

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_CTRL_EN_BIT 0
`define TMR_CTRL_RELOAD_BIT 1
`define TMR_CTRL_PRE_LSB 16
`define TMR_WD_EN_BIT 0
`define TMR_WD_PRE_LSB 16
`define TMR_ROUTE_NMI_BIT 0
`define TMR_STAT_WD_BIT 3

// ****************************************************************
// reset values
// ****************************************************************
`define TMR_CTRL_RST 32'h0000_0000
`define TMR_PERIOD_RST 32'hffff_ffff
`define TMR_MASK_RST 4'h0
`define TMR_WD_PERIOD_RST 16'hffff

// ****************************************************************
// timing
// ****************************************************************
`define TMR_CLK_MHZ 10
`define TMR_WD_PULSE_NS 1000
`define TMR_WD_PULSE_CYC ((`TMR_WD_PULSE_NS * `TMR_CLK_MHZ + 999) / 1000)

`endif

// [core/gp_timer_pkg.sv]
// types shared by the timer set
package gp_timer_pkg;
    typedef enum logic [1:0] {USE_NONE, USE_GP, USE_WD, USE_BOTH} wd_timer_use_t;
    typedef enum logic {RUN_IDLE, RUN_COUNT} run_state_t;
endpackage

// [core/gp_timer_chan.sv]
// one prescaled down-counter with optional auto-reload
`timescale 1ns/1ps
`default_nettype none
module gp_timer_chan
    import gp_timer_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int PRE_W = 13
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic start,
    input wire logic auto_reload,
    input wire logic [PRE_W-1:0] prescale,
    input wire logic [CNT_W-1:0] period,
    output logic [CNT_W-1:0] count,
    output logic expire
);
    initial
    begin
        if (CNT_W < 2 || PRE_W < 1)
            $error("gp_timer_chan: widths too small");
    end

    run_state_t state_r;
    logic [PRE_W-1:0] pre_r;
    logic [CNT_W-1:0] cnt_r;
    logic tick;

    assign tick = (state_r == RUN_COUNT) && (pre_r == prescale);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pre_r <= '0;
        else if (start || tick || state_r == RUN_IDLE)
            pre_r <= '0;
        else
            pre_r <= pre_r + 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= RUN_IDLE;
            cnt_r <= '0;
            expire <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            // start first: enable is still low in the cycle of the enabling write
            if (start)
            begin
                state_r <= RUN_COUNT;
                cnt_r <= period;
            end
            else if (!enable)
                state_r <= RUN_IDLE;
            else if (tick)
            begin
                if (cnt_r <= CNT_W'(1))
                begin
                    expire <= 1'b1;
                    if (auto_reload)
                        cnt_r <= period;
                    else
                    begin
                        cnt_r <= '0;
                        state_r <= RUN_IDLE;
                    end
                end
                else
                    cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign count = cnt_r;
endmodule // gp_timer_chan
`default_nettype wire

// [core/wd_reset_pulse.sv]
// stretches a watchdog expiry into an active-low reset pulse
`timescale 1ns/1ps
`default_nettype none
module wd_reset_pulse
#(
    parameter int PULSE_CYC = 10
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fire,
    output logic reset_out_n
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    initial
    begin
        if (PULSE_CYC < 1)
            $error("wd_reset_pulse: pulse length below one cycle");
    end

    logic [CW-1:0] left_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            left_r <= '0;
            reset_out_n <= 1'b1;
        end
        else if (fire)
        begin
            left_r <= CW'(PULSE_CYC - 1);
            reset_out_n <= 1'b0;
        end
        else if (left_r != '0)
            left_r <= left_r - 1'b1;
        else
            reset_out_n <= 1'b1;
    end
endmodule // wd_reset_pulse
`default_nettype wire

// [core/gp_watchdog_timer_set.sv]
// top of the three-timer set with watchdog on the third timer
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_regs.svh"
module gp_watchdog_timer_set
    import gp_timer_pkg::*;
#(
    parameter int NUM_TMR = 3,
    parameter int CNT_W = 32,
    parameter int PRE_W = 13,
    parameter int WD_CNT_W = 16,
    parameter int WD_PRE_W = 16
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [`TMR_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic ORDINARY_TICK_IRQ,
    output logic NMI_IRQ,
    output logic [NUM_TMR-1:0] DMA_EVT,
    output logic WD_RESET_N
);
    initial
    begin
        if (NUM_TMR != 3)
            $error("gp_watchdog_timer_set: exactly three timers are supported");
        if (CNT_W != 32)
            $error("gp_watchdog_timer_set: timer counters must be 32 bits");
        if (PRE_W < 1 || PRE_W > 16)
            $error("gp_watchdog_timer_set: timer prescaler must fit bits 31:16");
        if (WD_CNT_W < 2 || WD_CNT_W > 32)
            $error("gp_watchdog_timer_set: watchdog counter width out of range");
        if (WD_PRE_W < 1 || WD_PRE_W > 16)
            $error("gp_watchdog_timer_set: watchdog prescaler must fit bits 31:16");
    end

    localparam int NST = NUM_TMR + 1;

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [NUM_TMR-1:0] en_r;
    logic [NUM_TMR-1:0] reload_r;
    logic [PRE_W-1:0] pre_r [NUM_TMR];
    logic [CNT_W-1:0] period_r [NUM_TMR];
    logic [CNT_W-1:0] count_w [NUM_TMR];
    logic [NUM_TMR-1:0] start_w;
    logic [NUM_TMR-1:0] expire_w;
    logic [NST-1:0] stat_r;
    logic [NST-1:0] stat_nxt;
    logic [NST-1:0] mask_r;
    logic wd_en_r;
    logic [WD_PRE_W-1:0] wd_pre_r;
    logic [WD_CNT_W-1:0] wd_period_r;
    logic [WD_CNT_W-1:0] wd_count_w;
    logic wd_start;
    logic wd_expire;
    logic route_nmi_r;
    logic irq_any;
    wd_timer_use_t wd_use;
    logic wd_run;
    logic wd_ctrl_wr;
    logic wd_period_wr;
    logic wd_kick_wr;
    logic stat_wr;
    logic mask_wr;
    logic route_wr;
    logic [NST-1:0] stat_set;
    logic [31:0] rdata_nxt;

    // ****************************************************************
    // address decode of the shared registers
    // ****************************************************************
    // one strobe qualifies each shared register write
    assign wd_ctrl_wr = WR && ADDR == `TMR_WD_CTRL_ADDR;
    assign wd_period_wr = WR && ADDR == `TMR_WD_PERIOD_ADDR;
    assign wd_kick_wr = WR && ADDR == `TMR_WD_KICK_ADDR;
    assign stat_wr = WR && ADDR == `TMR_IRQ_STAT_ADDR;
    assign mask_wr = WR && ADDR == `TMR_IRQ_MASK_ADDR;
    assign route_wr = WR && ADDR == `TMR_ROUTE_ADDR;

    // ****************************************************************
    // general-purpose timers
    // ****************************************************************
    // three independent timers
    genvar g;
    generate
        for (g = 0; g < NUM_TMR; g++)
        begin : g_tmr
            localparam logic [7:0] BASE = 8'(g) * `TMR_BANK_STRIDE;
            logic ctrl_hit;
            logic period_hit;

            assign ctrl_hit = WR && ADDR == BASE + `TMR_CTRL_OFS;
            assign period_hit = WR && ADDR == BASE + `TMR_PERIOD_OFS;
            // writing the control word with enable set (re)starts the count
            assign start_w[g] = ctrl_hit && WDATA[`TMR_CTRL_EN_BIT];

            always_ff @(posedge CLK or negedge ARST_N)
            begin
                if (!ARST_N)
                begin
                    en_r[g] <= 1'b0;
                    reload_r[g] <= 1'b0;
                    pre_r[g] <= '0;
                end
                else if (ctrl_hit)
                begin
                    en_r[g] <= WDATA[`TMR_CTRL_EN_BIT];
                    reload_r[g] <= WDATA[`TMR_CTRL_RELOAD_BIT];
                    pre_r[g] <= WDATA[`TMR_CTRL_PRE_LSB +: PRE_W];
                end
            end

            // a new period takes effect at the next start or reload
            always_ff @(posedge CLK or negedge ARST_N)
            begin
                if (!ARST_N)
                    period_r[g] <= `TMR_PERIOD_RST;
                else if (period_hit)
                    period_r[g] <= WDATA[CNT_W-1:0];
            end

            gp_timer_chan #(
                .CNT_W(CNT_W),
                .PRE_W(PRE_W)
            ) u_chan (
                .clk(CLK),
                .arst_n(ARST_N),
                .enable(en_r[g]),
                .start(start_w[g]),
                .auto_reload(reload_r[g]),
                .prescale(pre_r[g]),
                .period(period_r[g]),
                .count(count_w[g]),
                .expire(expire_w[g])
            );
        end
    endgenerate

    // ****************************************************************
    // watchdog on the third timer
    // ****************************************************************
    // only the third timer has watchdog use
    assign wd_use = wd_timer_use_t'({wd_en_r, en_r[NUM_TMR-1]});
    // a kick or an enabling control write reloads the watchdog
    assign wd_start = wd_kick_wr || (wd_ctrl_wr && WDATA[`TMR_WD_EN_BIT]);

    // ****************************************************************
    // watchdog use of the third timer
    // ****************************************************************
    always_comb
    begin
        unique case (wd_use)
            USE_NONE: wd_run = 1'b0;
            USE_GP: wd_run = 1'b0;
            USE_WD: wd_run = 1'b1;
            USE_BOTH: wd_run = 1'b1;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wd_en_r <= 1'b0;
            wd_pre_r <= '0;
        end
        else if (wd_ctrl_wr)
        begin
            wd_en_r <= WDATA[`TMR_WD_EN_BIT];
            wd_pre_r <= WDATA[`TMR_WD_PRE_LSB +: WD_PRE_W];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            wd_period_r <= `TMR_WD_PERIOD_RST;
        else if (wd_period_wr)
            wd_period_r <= WDATA[WD_CNT_W-1:0];
    end

    gp_timer_chan #(
        .CNT_W(WD_CNT_W),
        .PRE_W(WD_PRE_W)
    ) u_wd (
        .clk(CLK),
        .arst_n(ARST_N),
        .enable(wd_run),
        .start(wd_start),
        .auto_reload(1'b0),
        .prescale(wd_pre_r),
        .period(wd_period_r),
        .count(wd_count_w),
        .expire(wd_expire)
    );

    wd_reset_pulse #(
        .PULSE_CYC(`TMR_WD_PULSE_CYC)
    ) u_rst (
        .clk(CLK),
        .arst_n(ARST_N),
        .fire(wd_expire),
        .reset_out_n(WD_RESET_N)
    );

    // ****************************************************************
    // interrupt latches and routing
    // ****************************************************************
    assign stat_set = {wd_expire, expire_w};

    // per-timer latch, set wins over clear
    always_comb
    begin
        stat_nxt = stat_r;
        if (stat_wr)
            stat_nxt = stat_r & ~WDATA[NST-1:0];
        // an expiry in the clearing cycle keeps its bit set
        stat_nxt = stat_nxt | stat_set;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            stat_r <= '0;
        else
            stat_r <= stat_nxt;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            mask_r <= `TMR_MASK_RST;
        else if (mask_wr)
            mask_r <= WDATA[NST-1:0];
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            route_nmi_r <= 1'b0;
        else if (route_wr)
            route_nmi_r <= WDATA[`TMR_ROUTE_NMI_BIT];
    end

    // next status, so the line rises at the edge that sets the latch
    // periodic interrupt from latched expiries
    assign irq_any = |(stat_nxt & mask_r);

    // one shared interrupt, ordinary or non-maskable
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ORDINARY_TICK_IRQ <= 1'b0;
        else
            ORDINARY_TICK_IRQ <= irq_any && !route_nmi_r;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            NMI_IRQ <= 1'b0;
        else
            NMI_IRQ <= irq_any && route_nmi_r;
    end

    // unmasked: dma sees every general-purpose timer expiry whatever the interrupt mask; watchdog expiry gives no dma event
    // expiry as DMA event pulse
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            DMA_EVT <= '0;
        else
            DMA_EVT <= expire_w;
    end

    // ****************************************************************
    // register read port
    // ****************************************************************
    // unmapped addresses and idle cycles read as zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (RD)
        begin
            // timer banks
            for (int i = 0; i < NUM_TMR; i++)
            begin
                if (ADDR == 8'(i) * `TMR_BANK_STRIDE + `TMR_CTRL_OFS)
                begin
                    rdata_nxt[`TMR_CTRL_EN_BIT] = en_r[i];
                    rdata_nxt[`TMR_CTRL_RELOAD_BIT] = reload_r[i];
                    rdata_nxt[`TMR_CTRL_PRE_LSB +: PRE_W] = pre_r[i];
                end
                if (ADDR == 8'(i) * `TMR_BANK_STRIDE + `TMR_PERIOD_OFS)
                    rdata_nxt = period_r[i];
                if (ADDR == 8'(i) * `TMR_BANK_STRIDE + `TMR_COUNT_OFS)
                    rdata_nxt = count_w[i];
            end
            // shared registers
            unique case (ADDR)
                `TMR_IRQ_STAT_ADDR: rdata_nxt[NST-1:0] = stat_r;
                `TMR_IRQ_MASK_ADDR: rdata_nxt[NST-1:0] = mask_r;
                `TMR_WD_CTRL_ADDR:
                begin
                    rdata_nxt[`TMR_WD_EN_BIT] = wd_en_r;
                    rdata_nxt[`TMR_WD_PRE_LSB +: WD_PRE_W] = wd_pre_r;
                end
                `TMR_WD_PERIOD_ADDR: rdata_nxt[WD_CNT_W-1:0] = wd_period_r;
                `TMR_ROUTE_ADDR: rdata_nxt[`TMR_ROUTE_NMI_BIT] = route_nmi_r;
                `TMR_WD_COUNT_ADDR: rdata_nxt[WD_CNT_W-1:0] = wd_count_w;
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            RDATA <= 32'h0000_0000;
        else
            RDATA <= rdata_nxt;
    end
endmodule // gp_watchdog_timer_set
`default_nettype wire

// [tb/gp_timer_set_chk.sv]
// port assertions for the timer set
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_regs.svh"
module gp_timer_set_chk
#(
    parameter int NUM_TMR = 3
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [`TMR_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic ORDINARY_TICK_IRQ,
    input wire logic NMI_IRQ,
    input wire logic [NUM_TMR-1:0] DMA_EVT,
    input wire logic WD_RESET_N
);
// ****************************************************************
// assertions
// ****************************************************************
default clocking cb @(posedge CLK); endclocking
default disable iff (!ARST_N);
a_one_route: assert property (!(ORDINARY_TICK_IRQ && NMI_IRQ)) else $error("both irqs");
a_tick_cause: assert property ($rose(ORDINARY_TICK_IRQ) && !$past(WR) && !$past(WR, 2)
    |-> ##[0:2] (DMA_EVT != '0 || !WD_RESET_N)) else $error("tick irq without expiry");
a_nmi_cause: assert property ($rose(NMI_IRQ) && !$past(WR) && !$past(WR, 2)
    |-> ##[0:2] (DMA_EVT != '0 || !WD_RESET_N)) else $error("nmi without expiry");
a_tick_latched: assert property ($fell(ORDINARY_TICK_IRQ) |-> $past(WR) || $past(WR, 2))
    else $error("tick irq dropped without write");
a_nmi_latched: assert property ($fell(NMI_IRQ) |-> $past(WR) || $past(WR, 2))
    else $error("nmi dropped without write");
a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("rdata not idle");
a_pulse_len: assert property ($fell(WD_RESET_N)
    |-> (!WD_RESET_N)[*8] ##1 (!WD_RESET_N)[*2] ##1 WD_RESET_N) else $error("pulse width");
a_pulse_end: assert property ($rose(WD_RESET_N)
    |-> !$past(WD_RESET_N, 10) && $past(WD_RESET_N, 11)) else $error("pulse end");
endmodule // gp_timer_set_chk
`default_nettype wire

// [tb/evt_sink.sv]
// model of the reset and dma event consumers
`timescale 1ns/1ps
`default_nettype none
module evt_sink
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] dma,
    input wire logic rst_in_n,
    output logic [2:0][7:0] hits,
    output logic [2:0][15:0] gap,
    output logic [7:0] low_len
);
    logic [2:0][15:0] since_r;
    logic rst_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hits <= '0;
            gap <= '0;
            since_r <= '0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                since_r[i] <= dma[i] ? 16'h0 : since_r[i] + 16'h1;
                if (dma[i])
                begin
                    hits[i] <= hits[i] + 8'h1;
                    gap[i] <= since_r[i] + 16'h1;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_len <= 8'h0;
            rst_q <= 1'b1;
        end
        else
        begin
            rst_q <= rst_in_n;
            if (!rst_in_n)
                low_len <= rst_q ? 8'h1 : low_len + 8'h1;
        end
    end
endmodule // evt_sink
`default_nettype wire

// [tb/tb_gp_watchdog_timer_set.sv]
// self-checking bench for the three-timer set
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_gp_watchdog_timer_set;
    logic clk, arst_n, wr, rd, rd_q, tick_irq, nmi_irq, wd_rst_n;
    logic [7:0] addr, h, low_len;
    logic [31:0] wdata, rdata, seed, exp_v;
    logic [2:0] dma_evt;
    logic [2:0][7:0] hits;
    logic [2:0][15:0] gap;
    logic [31:0] exp_q[$];
    logic [31:0] n[3];
    logic [31:0] p[3];
    logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h14, 8'h24, 8'h30, 8'h34, 8'h3c, 8'h44, 8'h4c};
    logic [31:0] rv[9] = '{0, `TMR_PERIOD_RST, `TMR_PERIOD_RST, `TMR_PERIOD_RST, 0, 0,
        32'h0000ffff, 0, 0};
    int errors, num_checks, cyc;
    gp_watchdog_timer_set DUT (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .ORDINARY_TICK_IRQ(tick_irq), .NMI_IRQ(nmi_irq),
        .DMA_EVT(dma_evt), .WD_RESET_N(wd_rst_n));
    evt_sink u_sink (.clk(clk), .arst_n(arst_n), .dma(dma_evt), .rst_in_n(wd_rst_n),
        .hits(hits), .gap(gap), .low_len(low_len));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
// ****************************************************************
// clock, monitor, timeout
// ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (rd_q)
        begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
        rd_q <= rd;
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            end_sim();
        end
    end
// ****************************************************************
// scenarios
// ****************************************************************
    initial
    begin
        {arst_n, wr, rd, rd_q, addr, wdata} = '0;
        seed = 32'd70409;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd_chk(ra[i], rv[i]);
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            n[i] = 32'h2 + seed[1:0];
            p[i] = {30'h0, seed[5:4]};
            bus(1'b1, 8'(i * 16 + 4), n[i]);
            bus(1'b1, 8'(i * 16), {3'h0, p[i][12:0], 14'h0, 2'b11});
        end
        for (int k = 0; k < 400 && (hits[0] < 3 || hits[1] < 3 || hits[2] < 3); k++)
            @(posedge clk);
        for (int i = 0; i < 3; i++)
            `CHK(gap[i], 16'(n[i] * (p[i] + 1)))
        for (int i = 0; i < 3; i++)
            bus(1'b1, 8'(i * 16), 32'h0);
        rd_chk(8'h30, 32'h7);
        bus(1'b1, 8'h34, 32'h1);
        bus(1'b1, 8'h44, 32'h0);
        repeat (3) @(posedge clk);
        `CHK({tick_irq, nmi_irq}, 2'b10)
        bus(1'b1, 8'h44, 32'h1);
        repeat (3) @(posedge clk);
        `CHK({tick_irq, nmi_irq}, 2'b01)
        bus(1'b1, 8'h30, 32'h7);
        rd_chk(8'h30, 32'h0);
        `CHK(nmi_irq, 1'b0)
        bus(1'b1, 8'h34, 32'ha);
        bus(1'b1, 8'h44, 32'h0);
        h = hits[1];
        bus(1'b1, 8'h14, 32'h3);
        bus(1'b1, 8'h10, 32'h0001_0001);
        for (int k = 0; k < 100 && hits[1] == h; k++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        `CHK(hits[1], h + 8'h1)
        `CHK(tick_irq, 1'b1)
        rd_chk(8'h18, 32'h0);
        bus(1'b1, 8'h18, 32'h5);
        rd_chk(8'h18, 32'h0);
        bus(1'b1, 8'h30, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(tick_irq, 1'b0)
        bus(1'b1, 8'h44, 32'h1);
        bus(1'b1, 8'h3c, 32'h2);
        bus(1'b1, 8'h38, 32'h1);
        for (int k = 0; k < 300 && wd_rst_n; k++)
            @(posedge clk);
        for (int k = 0; k < 50 && !wd_rst_n; k++)
            @(posedge clk);
        @(posedge clk);
        `CHK(low_len, 8'(`TMR_WD_PULSE_CYC))
        `CHK(nmi_irq, 1'b1)
        rd_chk(8'h30, 32'h8);
        bus(1'b1, 8'h30, 32'h8);
        bus(1'b1, 8'h20, 32'h3);
        bus(1'b1, 8'h3c, 32'h8);
        bus(1'b1, 8'h38, 32'h1);
        repeat (6)
            bus(1'b1, 8'h40, 32'h0);
        rd_chk(8'h48, 32'h7);
        `CHK(wd_rst_n, 1'b1)
        bus(1'b1, 8'h38, 32'h0);
        bus(1'b1, 8'h20, 32'h0);
        repeat (20) @(posedge clk);
        `CHK(wd_rst_n, 1'b1)
        end_sim();
    end
endmodule // tb_gp_watchdog_timer_set
bind gp_watchdog_timer_set gp_timer_set_chk #(.NUM_TMR(NUM_TMR)) u_chk (.CLK(CLK),
    .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ORDINARY_TICK_IRQ(ORDINARY_TICK_IRQ), .NMI_IRQ(NMI_IRQ), .DMA_EVT(DMA_EVT),
    .WD_RESET_N(WD_RESET_N));
`default_nettype wire
